//--- rsg_cnt_model.sv
// rsg_cnt_model: statistics counters and port supervisor at the far side of the generator.
// assumes increments are sampled at the rising edge of clk and cleared by the port reset.
`timescale 1ns/1ps

module rsg_cnt_model (
    input  wire logic        clk,          // receive core clock
    input  wire logic        rst,          // port reset
    input  wire logic [1:0]  pkt_inc,      // total packet increment
    input  wire logic [13:0] gbyte_inc,    // good byte increment
    input  wire logic        fifo_error,   // fifo fault pulse
    output logic      [31:0] pkt_cnt_q,    // accumulated packets
    output logic      [31:0] gbyte_cnt_q,  // accumulated good bytes
    output logic             port_rst_req  // asks for a port reset
);
    // accumulate every increment, cleared with the port
    always_ff @(posedge clk) begin
        if (rst) begin
            pkt_cnt_q   <= 32'h0;
            gbyte_cnt_q <= 32'h0;
        end else begin
            pkt_cnt_q   <= pkt_cnt_q + 32'(pkt_inc);
            gbyte_cnt_q <= gbyte_cnt_q + 32'(gbyte_inc);
        end
    end

    // a single fifo fault cycle means counts are untrusted until the port is reset
    always_ff @(posedge clk) begin
        if (rst) begin
            port_rst_req <= 1'b0;
        end else if (fifo_error) begin
            port_rst_req <= 1'b1;
        end
    end
endmodule

//--- rsg_pkg.sv
// rsg_pkg: constants for the receive statistics increment generator.
// assumes one packet at most ends per clock and a beat carries up to 32 bytes.
package rsg_pkg;

    // widths of the beat byte count, the packet length accumulator and the good byte increment, then the bin count
    localparam int RSG_BEAT_W   = 6;
    localparam int RSG_LEN_W    = 16;
    localparam int RSG_GBYTES_W = 14;
    localparam int RSG_BINS     = 7;

    // reset value of the length accumulator, then the saturation limits
    localparam logic [RSG_LEN_W-1:0] RSG_LEN_RST  = 16'h0000;
    localparam logic [RSG_LEN_W-1:0] RSG_LEN_SAT  = 16'hFFFF;
    localparam logic [RSG_GBYTES_W-1:0] RSG_GB_SAT = 14'h3FFF;

    // length limits fixed by the hardware
    localparam logic [RSG_LEN_W-1:0] RSG_DROP_BELOW = 16'h0010;  // 16 bytes
    localparam logic [RSG_LEN_W-1:0] RSG_SMALL_BELOW = 16'h0040; // 64 bytes
    localparam logic [RSG_LEN_W-1:0] RSG_LARGE_ABOVE = 16'h23FF; // 9215 bytes

    // histogram class bounds, bin 0 is 64 bytes, bin 6 is 1519..1522
    localparam logic [RSG_BINS-1:0][RSG_LEN_W-1:0] RSG_BIN_LO = {
        16'h05EF, 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0041, 16'h0040};
    localparam logic [RSG_BINS-1:0][RSG_LEN_W-1:0] RSG_BIN_HI = {
        16'h05F2, 16'h05EE, 16'h03FF, 16'h01FF, 16'h00FF, 16'h007F, 16'h0040};

    // core configuration: mac included or pcs/pma only
    typedef enum logic {RSG_CFG_PCS_ONLY, RSG_CFG_MAC_PCS} rsg_cfg_t;

endpackage

//--- rsg_rx_stats_gen.sv
// rsg_rx_stats_gen: per-cycle receive statistics increments for an ethernet port.
// assumes beat inputs synchronous to clk and at most one packet end per beat.
`timescale 1ns/1ps

module rsg_rx_stats_gen
    import rsg_pkg::*;
#(
    parameter rsg_cfg_t CORE_CFG = RSG_CFG_MAC_PCS   // which outputs can be nonzero
) (
    input  wire logic                    clk,                  // receive core clock
    input  wire logic                    rst,                  // port reset, sync, high
    input  wire logic                    rx_beat_valid,        // a data beat this cycle
    input  wire logic                    rx_beat_sop,          // beat starts a packet
    input  wire logic                    rx_beat_eop,          // beat ends a packet
    input  wire logic [RSG_BEAT_W-1:0]   rx_beat_bytes,        // valid bytes in beat
    input  wire logic                    rx_fcs_bad,           // fcs wrong, with eop
    input  wire logic                    rx_pkt_err,           // other packet error, with eop
    input  wire logic [RSG_LEN_W-1:0]    max_packet_len,       // longest legal frame
    input  wire logic [RSG_LEN_W-1:0]    min_packet_len,       // shortest legal frame
    input  wire logic                    fifo_underflow,       // receive fifo ran dry
    input  wire logic                    fifo_overflow,        // receive fifo overran
    output logic                         fifo_error,           // fifo fault pulse
    output logic [1:0]                   total_packets_inc,    // every counted packet
    output logic                         good_packets_inc,     // error-free packets
    output logic [RSG_BEAT_W-1:0]        total_bytes_inc,      // bytes per beat
    output logic [RSG_GBYTES_W-1:0]      good_bytes_inc,       // bytes of good packet
    output logic [1:0]                   small_inc,            // under 64 bytes
    output logic                         jabber_inc,           // long, bad fcs
    output logic                         large_inc,            // over 9215 bytes
    output logic                         oversize_inc,         // long, good fcs
    output logic [1:0]                   undersize_inc,        // short, good fcs
    output logic                         toolong_inc,          // long, any fcs
    output logic [1:0]                   fragment_inc,         // short, bad fcs
    output logic                         pkt_dropped,          // packet discarded
    output logic                         hist_64_inc,          // 64 bytes
    output logic                         hist_65_127_inc,      // 65..127
    output logic                         hist_128_255_inc,     // 128..255
    output logic                         hist_256_511_inc,     // 256..511
    output logic                         hist_512_1023_inc,    // 512..1023
    output logic                         hist_1024_1518_inc,   // 1024..1518
    output logic                         hist_1519_1522_inc    // 1519..1522
);

    // the build is fixed at elaboration: a mac build never shows the fifo fault,
    // and a pcs-only build keeps every packet and byte increment at zero, so the
    // far side can tie off whichever group its build does not carry
    // configuration decode
    wire has_mac = (CORE_CFG == RSG_CFG_MAC_PCS);

    // the length of a packet is the sum of the byte counts of its beats, from the
    // start beat through the end beat; a start beat restarts the sum, so a lost end
    // marker costs at most one wrong length and never leaks into the next packet
    // running length of the packet in flight
    logic [RSG_LEN_W-1:0]   len_q;               // bytes so far
    logic [RSG_LEN_W-1:0]   len_d;               // next running length
    logic [RSG_LEN_W:0]     len_sum;             // widened add for saturation
    wire  [RSG_LEN_W-1:0]   beat_len = {{(RSG_LEN_W-RSG_BEAT_W){1'b0}}, rx_beat_bytes};
    wire  [RSG_LEN_W-1:0]   len_base = rx_beat_sop ? RSG_LEN_RST : len_q;

    // len_d already holds the current beat, so the end beat is classified with its
    // own bytes included and the classes need no extra pipeline stage
    // the sum is one bit wider than the register so the carry can be seen
    // length add saturates so a runaway frame never wraps into a small class
    assign len_sum = {1'b0, len_base} + {1'b0, beat_len};
    assign len_d   = len_sum[RSG_LEN_W] ? RSG_LEN_SAT : len_sum[RSG_LEN_W-1:0];

    // a packet is finished by a valid beat that carries the end marker; a packet
    // under sixteen bytes is thrown away here and gives only the drop pulse, while
    // its bytes are still counted per beat
    // packet end qualification
    wire pkt_end  = rx_beat_valid && rx_beat_eop && has_mac;
    wire pkt_drop = pkt_end && (len_d < RSG_DROP_BELOW);
    wire pkt_cnt  = pkt_end && !pkt_drop;

    // long and short follow the configured limits and may change between packets;
    // small and large follow fixed limits; a frame may be long and large at once
    // size and fcs classes of the finished packet
    wire is_long   = len_d > max_packet_len;
    wire is_short  = len_d < min_packet_len;
    wire is_small  = len_d < RSG_SMALL_BELOW;
    wire is_large  = len_d > RSG_LARGE_ABOVE;
    wire is_good   = !rx_fcs_bad && !rx_pkt_err && !is_long && !is_short;

    // every class is gated by pkt_cnt, so nothing is issued between ends and a
    // dropped packet never reaches the long, short or good classes
    // next values of each increment
    wire       jabber_d    = pkt_cnt && is_long && rx_fcs_bad;
    wire       oversize_d  = pkt_cnt && is_long && !rx_fcs_bad;
    wire       toolong_d   = pkt_cnt && is_long;
    wire       undersize_d = pkt_cnt && is_short && !rx_fcs_bad;
    wire       fragment_d  = pkt_cnt && is_short && rx_fcs_bad;
    wire       good_d      = pkt_cnt && is_good;
    wire [RSG_GBYTES_W-1:0] gbytes_d =
        !good_d ? '0 : ((len_d > {2'b00, RSG_GB_SAT}) ? RSG_GB_SAT : len_d[RSG_GBYTES_W-1:0]);
    wire [RSG_BEAT_W-1:0]   tbytes_d = (rx_beat_valid && has_mac) ? rx_beat_bytes : '0;
    wire       fifo_err_d  = !has_mac && (fifo_underflow || fifo_overflow);

    // the classes are disjoint, so at most one bin fires for a packet; lengths
    // under 64 or over 1522 bytes fall in no bin at all
    // histogram bin match, one comparator pair per class
    logic [RSG_BINS-1:0] hist_d;                 // bin hits of finished packet
    logic [RSG_BINS-1:0] hist_q;                 // registered bin increments
    genvar b;
    generate
        for (b = 0; b < RSG_BINS; b++) begin : g_bin
            assign hist_d[b] = pkt_cnt && (len_d >= RSG_BIN_LO[b]) && (len_d <= RSG_BIN_HI[b]);
        end
    endgenerate

    // all increments leave from flip-flops so the far side sees clean pulses
    // registered increments
    logic                    fifo_err_q;
    logic                    total_q;
    logic                    good_q;
    logic [RSG_BEAT_W-1:0]   tbytes_q;
    logic [RSG_GBYTES_W-1:0] gbytes_q;
    logic                    small_q;
    logic                    jabber_q;
    logic                    large_q;
    logic                    oversize_q;
    logic                    undersize_q;
    logic                    toolong_q;
    logic                    fragment_q;
    logic                    drop_q;

    // the length only moves on a valid beat; idle cycles inside a packet keep it
    // running length register
    always_ff @(posedge clk) begin
        if (rst) begin
            len_q <= RSG_LEN_RST;
        end else if (rx_beat_valid) begin
            len_q <= len_d;
        end
    end

    // one cycle of latency from the beat to its increments, for every class alike,
    // so a counter on the far side can add all of them in the same cycle
    // every increment is reloaded each cycle, so a count lasts one cycle only
    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_err_q  <= 1'b0;
            total_q     <= 1'b0;
            good_q      <= 1'b0;
            tbytes_q    <= '0;
            gbytes_q    <= '0;
            small_q     <= 1'b0;
            jabber_q    <= 1'b0;
            large_q     <= 1'b0;
            oversize_q  <= 1'b0;
            undersize_q <= 1'b0;
            toolong_q   <= 1'b0;
            fragment_q  <= 1'b0;
            drop_q      <= 1'b0;
            hist_q      <= '0;
        end else begin
            fifo_err_q  <= fifo_err_d;
            total_q     <= pkt_cnt;
            good_q      <= good_d;
            tbytes_q    <= tbytes_d;
            gbytes_q    <= gbytes_d;
            small_q     <= pkt_cnt && is_small;
            jabber_q    <= jabber_d;
            large_q     <= pkt_cnt && is_large;
            oversize_q  <= oversize_d;
            undersize_q <= undersize_d;
            toolong_q   <= toolong_d;
            fragment_q  <= fragment_d;
            drop_q      <= pkt_drop;
            hist_q      <= hist_d;
        end
    end

    // the upper bit of each two-bit increment is held at zero because no more
    // than one packet ends in a beat; the width is kept for the counter side
    // output mapping, two-bit counts carry at most one packet per cycle
    assign fifo_error         = fifo_err_q;
    assign total_packets_inc  = {1'b0, total_q};
    assign good_packets_inc   = good_q;
    assign total_bytes_inc    = tbytes_q;
    assign good_bytes_inc     = gbytes_q;
    assign small_inc          = {1'b0, small_q};
    assign jabber_inc         = jabber_q;
    assign large_inc          = large_q;
    assign oversize_inc       = oversize_q;
    assign undersize_inc      = {1'b0, undersize_q};
    assign toolong_inc        = toolong_q;
    assign fragment_inc       = {1'b0, fragment_q};
    assign pkt_dropped        = drop_q;
    assign hist_64_inc        = hist_q[0];
    assign hist_65_127_inc    = hist_q[1];
    assign hist_128_255_inc   = hist_q[2];
    assign hist_256_511_inc   = hist_q[3];
    assign hist_512_1023_inc  = hist_q[4];
    assign hist_1024_1518_inc = hist_q[5];
    assign hist_1519_1522_inc = hist_q[6];

    // the packet checks look at the registered outputs one cycle after the packet end
    // that caused them; all are off while the port reset is high
    // checks on the design's own outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a finished packet that is counted
    sequence counted_end_s;
        rx_beat_valid && rx_beat_eop && has_mac && (len_d >= RSG_DROP_BELOW);
    endsequence

    // a finished packet that is discarded
    sequence dropped_end_s;
        rx_beat_valid && rx_beat_eop && has_mac && (len_d < RSG_DROP_BELOW);
    endsequence

    fifo_err_follow_a: assert property ((fifo_underflow || fifo_overflow) && !has_mac |=> fifo_error)
        else $error("fifo fault not flagged");
    cfg_split_a: assert property (has_mac ? !fifo_error : (total_packets_inc == 2'b00 && total_bytes_inc == '0))
        else $error("output active in wrong configuration");
    total_pkt_a: assert property (counted_end_s |=> total_packets_inc == 2'b01)
        else $error("total packet increment wrong");
    good_pkt_a: assert property (good_packets_inc |-> $past(!rx_fcs_bad && !rx_pkt_err && rx_beat_eop))
        else $error("good packet counted with error");
    total_bytes_a: assert property (rx_beat_valid && has_mac |=> total_bytes_inc == $past(rx_beat_bytes))
        else $error("byte increment differs from beat");
    good_bytes_a: assert property ((good_bytes_inc != '0) |-> good_packets_inc)
        else $error("good bytes without good packet");
    drop_quiet_a: assert property (dropped_end_s |=> pkt_dropped && total_packets_inc == 2'b00 && small_inc == 2'b00)
        else $error("short packet not discarded");
    small_pkt_a: assert property (counted_end_s and (len_d < RSG_SMALL_BELOW) |=> small_inc == 2'b01)
        else $error("small packet not counted");
    long_split_a: assert property (toolong_inc == (jabber_inc || oversize_inc) && !(jabber_inc && oversize_inc))
        else $error("long packet classes disagree");
    short_split_a: assert property (!(undersize_inc[0] && fragment_inc[0]))
        else $error("undersize and fragment together");
    large_pkt_a: assert property (counted_end_s and (len_d > RSG_LARGE_ABOVE) |=> large_inc)
        else $error("large packet missed");
    hist_once_a: assert property ($onehot0(hist_q) && (hist_q == '0 || total_packets_inc == 2'b01))
        else $error("histogram not one bin at packet end");
    pulse_only_a: assert property (!(rx_beat_valid && rx_beat_eop) |=> total_packets_inc == 2'b00 && hist_q == '0)
        else $error("increment without packet end");

    // the checks below rebuild each class from the inputs of the end beat, so a
    // broken comparator is caught rather than copied into the expectation

    // a counted end whose length runs past the configured maximum
    sequence long_end_s;
        counted_end_s ##0 (len_d > max_packet_len);
    endsequence

    // a counted end whose length falls under the configured minimum
    sequence short_end_s;
        counted_end_s ##0 (len_d < min_packet_len);
    endsequence

    // a counted end with no fault of any kind and a legal length
    sequence clean_end_s;
        counted_end_s ##0 (!rx_fcs_bad && !rx_pkt_err && (len_d <= max_packet_len) && (len_d >= min_packet_len));
    endsequence

    // long frame with a bad fcs
    jabber_hit_a: assert property (long_end_s ##0 rx_fcs_bad |=> jabber_inc && toolong_inc)
        else $error("jabber packet missed");

    // long frame with a good fcs
    oversize_hit_a: assert property (long_end_s ##0 !rx_fcs_bad |=> oversize_inc && toolong_inc)
        else $error("oversize packet missed");

    // short frame with a good fcs
    undersize_hit_a: assert property (short_end_s ##0 !rx_fcs_bad |=> undersize_inc == 2'b01)
        else $error("undersize packet missed");

    // short frame with a bad fcs
    fragment_hit_a: assert property (short_end_s ##0 rx_fcs_bad |=> fragment_inc == 2'b01)
        else $error("fragment packet missed");

    // a clean packet is counted good, with its bytes
    good_hit_a: assert property (clean_end_s |=> good_packets_inc && good_bytes_inc != '0)
        else $error("clean packet not counted good");

    // a faulty packet adds nothing to the good counts
    bad_quiet_a: assert property (counted_end_s ##0 (rx_fcs_bad || rx_pkt_err) |=> !good_packets_inc && good_bytes_inc == '0)
        else $error("faulty packet counted good");

    // the two lowest bins
    hist_low_a: assert property (counted_end_s ##0 (len_d >= RSG_BIN_LO[0]) && (len_d <= RSG_BIN_HI[1]) |=> hist_q[1:0] != '0)
        else $error("low histogram bin missed");

    // the three middle bins
    hist_mid_a: assert property (counted_end_s ##0 (len_d >= RSG_BIN_LO[2]) && (len_d <= RSG_BIN_HI[4]) |=> hist_q[4:2] != '0)
        else $error("middle histogram bin missed");

    // the two top bins
    hist_top_a: assert property (counted_end_s ##0 (len_d >= RSG_BIN_LO[5]) && (len_d <= RSG_BIN_HI[6]) |=> hist_q[6:5] != '0)
        else $error("top histogram bin missed");

    // frames past the top bin fall in none
    hist_out_a: assert property (counted_end_s ##0 (len_d > RSG_BIN_HI[6]) |=> hist_q == '0)
        else $error("histogram bin for oversized frame");

    // large only for frames past the fixed limit
    large_only_a: assert property (large_inc |-> $past(len_d) > RSG_LARGE_ABOVE)
        else $error("large flagged for short frame");

    // no bytes counted in a cycle without a beat
    bytes_idle_a: assert property (!rx_beat_valid |=> total_bytes_inc == '0)
        else $error("bytes counted without beat");

    // the fifo fault pulse ends with the fault
    fifo_quiet_a: assert property (!(fifo_underflow || fifo_overflow) |=> !fifo_error)
        else $error("fifo fault without cause");

    // upper bits of the total and small two-bit counts stay clear
    count_top_a: assert property (total_packets_inc[1] == 1'b0 && small_inc[1] == 1'b0)
        else $error("two-bit count upper bit set");

endmodule

//--- tb_top.sv
// tb_top: self-checking bench for the receive statistics increment generator.
// assumes both core configurations are built and inputs change at the falling edge.
`timescale 1ns/1ps

module tb_top;
    import rsg_pkg::*;
    logic        clk, rst, vld, sop, eop, fcs, perr, unf, ovf;  // bench-driven inputs
    logic [5:0]  bytes, tb_inc;                                 // beat bytes in and out
    logic [15:0] max_len, min_len;                              // frame limits
    logic        fe_mac, fe_pcs, gp, jab, lrg, ovs, tln, drp;   // one-bit outputs
    logic [1:0]  tp, sml, und, frg, tp_pcs;                     // two-bit outputs
    logic [13:0] gb;                                            // good bytes
    logic [6:0]  hist;                                          // histogram, bin 0 first
    logic [34:0] pk, exp_pk;                                    // packet-level results
    logic [31:0] pkt_cnt, gb_cnt;                               // far-side counters
    logic        rst_req;                                       // far side wants reset
    int          fails, tests_run, cycles, exp_pkts, exp_gb;    // bookkeeping
    assign pk = {tp, gp, gb, sml, jab, lrg, ovs, und, tln, frg, drp, hist};

    rsg_rx_stats_gen dut (.clk(clk), .rst(rst), .rx_beat_valid(vld), .rx_beat_sop(sop), .rx_beat_eop(eop),
        .rx_beat_bytes(bytes), .rx_fcs_bad(fcs), .rx_pkt_err(perr), .max_packet_len(max_len),
        .min_packet_len(min_len), .fifo_underflow(unf), .fifo_overflow(ovf), .fifo_error(fe_mac),
        .total_packets_inc(tp), .good_packets_inc(gp), .total_bytes_inc(tb_inc), .good_bytes_inc(gb),
        .small_inc(sml), .jabber_inc(jab), .large_inc(lrg), .oversize_inc(ovs), .undersize_inc(und),
        .toolong_inc(tln), .fragment_inc(frg), .pkt_dropped(drp), .hist_64_inc(hist[0]),
        .hist_65_127_inc(hist[1]), .hist_128_255_inc(hist[2]), .hist_256_511_inc(hist[3]),
        .hist_512_1023_inc(hist[4]), .hist_1024_1518_inc(hist[5]), .hist_1519_1522_inc(hist[6]));
    // pcs-only build sees the same stimulus
    rsg_rx_stats_gen #(.CORE_CFG(RSG_CFG_PCS_ONLY)) dut_pcs (.clk(clk), .rst(rst), .rx_beat_valid(vld),
        .rx_beat_sop(sop), .rx_beat_eop(eop), .rx_beat_bytes(bytes), .rx_fcs_bad(fcs), .rx_pkt_err(perr),
        .max_packet_len(max_len), .min_packet_len(min_len), .fifo_underflow(unf), .fifo_overflow(ovf),
        .fifo_error(fe_pcs), .total_packets_inc(tp_pcs), .good_packets_inc(), .total_bytes_inc(),
        .good_bytes_inc(), .small_inc(), .jabber_inc(), .large_inc(), .oversize_inc(), .undersize_inc(),
        .toolong_inc(), .fragment_inc(), .pkt_dropped(), .hist_64_inc(), .hist_65_127_inc(),
        .hist_128_255_inc(), .hist_256_511_inc(), .hist_512_1023_inc(), .hist_1024_1518_inc(),
        .hist_1519_1522_inc());
    rsg_cnt_model partner (.clk(clk), .rst(rst), .pkt_inc(tp), .gbyte_inc(gb), .fifo_error(fe_pcs),
        .pkt_cnt_q(pkt_cnt), .gbyte_cnt_q(gb_cnt), .port_rst_req(rst_req));

    // report one comparison
    task automatic cmp(input string name, input logic [34:0] e, input logic [34:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    // expected packet-level increments for a packet of len bytes
    function automatic logic [34:0] expect_pkt(input int len, input logic bad, input logic er);
        int          lo[7] = '{64, 65, 128, 256, 512, 1024, 1519};
        int          hi[7] = '{64, 127, 255, 511, 1023, 1518, 1522};
        logic        ok, lng, sht;
        logic [6:0]  h;
        logic [13:0] g;
        if (len < 16) return 35'h80;
        lng = len > max_len;
        sht = len < min_len;
        ok = !bad && !er && !lng && !sht;
        g = ok ? ((len > 16383) ? 14'h3FFF : 14'(len)) : 14'h0;
        for (int i = 0; i < 7; i++) h[i] = len >= lo[i] && len <= hi[i];
        return {2'h1, ok, g, 1'b0, len < 64, lng && bad, len > 9215, lng && !bad, 1'b0, sht && !bad, lng,
                1'b0, sht && bad, 1'b0, h};
    endfunction

    // one beat, then judge the cycle that answers it
    task automatic beat(input logic [5:0] n, input logic s, input logic e, input logic b, input logic r);
        vld = 1'b1;
        sop = s;
        eop = e;
        bytes = n;
        fcs = b;
        perr = r;
        @(negedge clk);
        cmp("total_bytes_inc", 35'(n), 35'(tb_inc));
        cmp("packet increments", e ? exp_pk : 35'h0, pk);
        cmp("pcs-only packets", 35'h0, 35'(tp_pcs));
    endtask

    // whole packet in 32-byte beats, back to back with the next
    task automatic send(input int len, input logic b, input logic r);
        int left;
        left = len;
        exp_pk = expect_pkt(len, b, r);
        exp_pkts += int'(exp_pk[34:33]);
        exp_gb += int'(exp_pk[31:18]);
        while (left > 32) begin
            beat(6'h20, left == len, 1'b0, 1'b0, 1'b0);
            left -= 32;
        end
        beat(6'(left), left == len, 1'b1, b, r);
    endtask

    // an idle cycle must carry no increment at all
    task automatic idle();
        vld = 1'b0;
        @(negedge clk);
        cmp("idle increments", 35'h0, pk);
        cmp("idle byte increment", 35'h0, 35'(tb_inc));
    endtask

    // every length class, boundaries, fcs and packet errors, then far-side totals
    task automatic run_lengths();
        int lens[17] = '{15, 16, 40, 63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519, 9216};
        foreach (lens[i]) send(lens[i], 1'b0, 1'b0);
        send(40, 1'b1, 1'b0);
        send(1522, 1'b1, 1'b0);
        send(100, 1'b0, 1'b1);
        idle();
        idle();
        cmp("packet count", 35'(exp_pkts), 35'(pkt_cnt));
        cmp("good byte count", 35'(exp_gb), 35'(gb_cnt));
    endtask

    // fifo faults pulse the error in pcs-only build only; the port is then reset
    task automatic run_fifo();
        unf = 1'b1;
        @(negedge clk);
        cmp("fifo error underflow", 35'h1, {33'h0, fe_mac, fe_pcs});
        unf = 1'b0;
        ovf = 1'b1;
        @(negedge clk);
        cmp("fifo error overflow", 35'h1, {33'h0, fe_mac, fe_pcs});
        ovf = 1'b0;
        @(negedge clk);
        cmp("fifo error cleared", 35'h1, {33'h0, fe_pcs, rst_req});
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        send(64, 1'b0, 1'b0);
        idle();
        cmp("reset request after port reset", 35'h0, 35'(rst_req));
        cmp("packet count after port reset", 35'h1, 35'(pkt_cnt));
    endtask

    // verdict and end of run
    task automatic test_done();
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard, far above the roughly 600 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    // main sequence
    initial begin
        {rst, vld, sop, eop, fcs, perr, unf, ovf} = 8'hFF & 8'h80;
        bytes = 6'h00;
        max_len = 16'h05EE;
        min_len = 16'h0040;
        {fails, tests_run, cycles, exp_pkts, exp_gb} = '0;
        exp_pk = 35'h0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        run_lengths();
        run_fifo();
        test_done();
    end
endmodule
